// File: hdl/power_mode_and_fault_irq_control.sv
/*
 Operating-mode controller with watchdog and fault/wake interrupt logic.
 Assumes all inputs synchronous to clk; mode_write and status_read are
 one-cycle strobes from the serial interface; wake and fault levels are clean.
*/
// Behaviour
// - Mode-select field written by the controller picks Normal, Stop or Sleep.
// - Stop keeps regulator at limited current; only a wake interrupt leaves it.
// - Sleep turns regulator off; wake turns it on and exits via reset.
// - Wake on wake-input change, LIN wake or select rise; select rise not in Sleep.
// - Stop/Sleep: LIN recessive, wake detect on, loads off; reset high/low.
// - Normal Request with watchdog enabled allows 150 ms, else watchdog failure.
// - Watchdog served by command; windowed watchdog runs in Normal when enabled.
// - Failure on missing service or service while the window is closed.
// - Grounded config pin disables watchdog; open pin uses the default period.
// - Normal mode knows four interrupt sources, each reported as a pulse.
// - No interrupt source can be masked or disabled.
// - Interrupt sets source flag; it clears after one transfer out.
// - Low main supply sets low-voltage flag and raises an interrupt.
// - Low-voltage flag follows the condition, neither latched nor read-cleared.
// - Low-voltage detection is off in Sleep and Stop.
// - In Normal both wake input levels are readable.
// - Switches one and two are gated by the PWM input and their on bits.
// - Switch three follows only its on bit.
// - Switch one or two is on only with on bit set and PWM high.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defines.svh"
module power_mode_and_fault_irq_control #(
	parameter logic [`CNT_W-1:0] NREQ_TIMEOUT = `CNT_W'(`NREQ_TIMEOUT_CYCLES),
	parameter logic [`CNT_W-1:0] WD_DEFAULT = `CNT_W'(`WD_DEFAULT_CYCLES),
	parameter logic [`CNT_W-1:0] RESET_HOLD = `CNT_W'(`RESET_HOLD_CYCLES)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic mode_write,
	input wire logic [1:0] mode_select_field,
	input wire logic status_read,
	input wire logic watchdog_config_pin_grounded,
	input wire logic watchdog_config_pin_open,
	input wire logic [`CNT_W-1:0] watchdog_resistor_period,
	input wire logic wake_input_one,
	input wire logic wake_input_two,
	input wire logic lin_wake,
	input wire logic slave_select,
	input wire logic main_supply_low,
	input wire logic [2:0] other_fault,
	input wire logic direct_pwm_gate_input,
	input wire logic switch_one_on_bit,
	input wire logic switch_two_on_bit,
	input wire logic switch_three_on_bit,
	output logic regulator_on,
	output logic regulator_limited,
	output logic reset_out_n,
	output logic watchdog_active,
	output logic high_side_switch_one,
	output logic high_side_switch_two,
	output logic high_side_switch_three,
	output logic lin_tx_enable,
	output logic lin_wake_detect_en,
	output logic sense_amp_en,
	output logic irq_n,
	output logic interrupt_source_flag,
	output logic low_voltage_flag,
	output logic wake_level_one,
	output logic wake_level_two,
	output logic in_normal
);
	pwr_pkg::mode_state_t state;
	pwr_pkg::mode_state_t next_state;
	logic [`CNT_W-1:0] hold_cnt;
	logic [`CNT_W-1:0] next_hold_cnt;
	logic wake_one_prev;
	logic wake_two_prev;
	logic ss_prev;
	logic lv_prev;
	logic [2:0] fault_prev;
	logic wd_enabled;
	logic wd_fail;
	logic wd_service;
	logic wd_restart;
	logic [`CNT_W-1:0] wd_period;
	logic pin_change;
	logic ss_rise;
	logic lv_rise;
	logic fault_rise;
	logic wake_sleep;
	logic wake_stop;
	logic irq_trigger;
	logic next_regulator_on;
	logic next_regulator_limited;
	logic next_reset_out_n;
	logic next_watchdog_active;
	logic next_hs_one;
	logic next_hs_two;
	logic next_hs_three;
	logic next_lin_tx_enable;
	logic next_lin_wake_detect_en;
	logic next_sense_amp_en;
	logic next_src_flag;
	logic next_lv_flag;
	logic next_wake_one;
	logic next_wake_two;

	function automatic logic is_cmd(input logic wr, input logic [1:0] field, input logic [1:0] code);
		return wr && (field == code);
	endfunction

	// Event detection against last-cycle levels
	assign pin_change = (wake_input_one != wake_one_prev) || (wake_input_two != wake_two_prev);
	assign ss_rise = slave_select && !ss_prev;
	assign lv_rise = main_supply_low && !lv_prev;
	assign fault_rise = |(other_fault & ~fault_prev);
	assign wake_sleep = pin_change || lin_wake;
	assign wake_stop = pin_change || lin_wake || ss_rise;

	assign wd_enabled = !watchdog_config_pin_grounded;
	assign wd_period = watchdog_config_pin_open ? WD_DEFAULT : watchdog_resistor_period;
	assign wd_service = (state == pwr_pkg::ST_NORMAL) && is_cmd(mode_write, mode_select_field, `MODE_NORMAL);
	assign wd_restart = (next_state != state);

	// Every qualifying event pulses; nothing gates it
	assign irq_trigger = ((state == pwr_pkg::ST_NORMAL) && (lv_rise || fault_rise)) ||
		((state == pwr_pkg::ST_STOP) && wake_stop);

	window_watchdog u_wd (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.restart(wd_restart),
		.req_phase(wd_enabled && (state == pwr_pkg::ST_NREQ)),
		.win_phase(wd_enabled && (state == pwr_pkg::ST_NORMAL)),
		.service(wd_service),
		.req_cycles(NREQ_TIMEOUT),
		.period_cycles(wd_period),
		.fail(wd_fail)
	);

	irq_pulse u_irq (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.trigger(irq_trigger),
		.irq_n(irq_n)
	);

	// Mode sequencing
	always_comb begin
		next_state = state;
		next_hold_cnt = `CNT_W'h0;
		case (state)
			pwr_pkg::ST_RESET: begin
				next_hold_cnt = hold_cnt + `CNT_W'h1;
				if (hold_cnt >= RESET_HOLD - `CNT_W'h1) begin
					next_state = pwr_pkg::ST_NREQ;
					next_hold_cnt = `CNT_W'h0;
				end
			end
			pwr_pkg::ST_NREQ, pwr_pkg::ST_NORMAL: begin
				if (wd_fail) begin
					next_state = pwr_pkg::ST_RESET;
				end else if (is_cmd(mode_write, mode_select_field, `MODE_NORMAL)) begin
					next_state = pwr_pkg::ST_NORMAL;
				end else if (is_cmd(mode_write, mode_select_field, `MODE_STOP)) begin
					next_state = pwr_pkg::ST_STOP;
				end else if (is_cmd(mode_write, mode_select_field, `MODE_SLEEP)) begin
					next_state = pwr_pkg::ST_SLEEP;
				end
			end
			pwr_pkg::ST_STOP: begin
				if (wake_stop) begin
					next_state = pwr_pkg::ST_NREQ;
				end
			end
			pwr_pkg::ST_SLEEP: begin
				if (wake_sleep) begin
					next_state = pwr_pkg::ST_RESET;
				end
			end
			default: begin
				next_state = pwr_pkg::ST_RESET;
			end
		endcase
	end

	// Outputs follow the coming mode so they line up with state
	always_comb begin
		next_regulator_on = (next_state != pwr_pkg::ST_SLEEP);
		next_regulator_limited = (next_state == pwr_pkg::ST_STOP);
		next_reset_out_n = !((next_state == pwr_pkg::ST_RESET) || (next_state == pwr_pkg::ST_SLEEP));
		next_watchdog_active = wd_enabled && ((next_state == pwr_pkg::ST_NREQ) || (next_state == pwr_pkg::ST_NORMAL));
		next_hs_one = (next_state == pwr_pkg::ST_NORMAL) && switch_one_on_bit && direct_pwm_gate_input;
		next_hs_two = (next_state == pwr_pkg::ST_NORMAL) && switch_two_on_bit && direct_pwm_gate_input;
		next_hs_three = (next_state == pwr_pkg::ST_NORMAL) && switch_three_on_bit;
		next_lin_tx_enable = (next_state == pwr_pkg::ST_NREQ) || (next_state == pwr_pkg::ST_NORMAL);
		next_lin_wake_detect_en = (next_state == pwr_pkg::ST_STOP) || (next_state == pwr_pkg::ST_SLEEP);
		next_sense_amp_en = (next_state == pwr_pkg::ST_NORMAL);
		next_lv_flag = (next_state == pwr_pkg::ST_NORMAL) && main_supply_low;
		next_wake_one = (next_state == pwr_pkg::ST_NORMAL) && wake_input_one;
		next_wake_two = (next_state == pwr_pkg::ST_NORMAL) && wake_input_two;
		// Set wins over the clear by a transfer out
		next_src_flag = irq_trigger || (interrupt_source_flag && !status_read);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= pwr_pkg::ST_RESET;
			hold_cnt <= `CNT_W'h0;
			wake_one_prev <= 1'b0;
			wake_two_prev <= 1'b0;
			ss_prev <= 1'b0;
			lv_prev <= 1'b0;
			fault_prev <= 3'h0;
			regulator_on <= 1'b1;
			regulator_limited <= 1'b0;
			reset_out_n <= 1'b0;
			watchdog_active <= 1'b0;
			high_side_switch_one <= 1'b0;
			high_side_switch_two <= 1'b0;
			high_side_switch_three <= 1'b0;
			lin_tx_enable <= 1'b0;
			lin_wake_detect_en <= 1'b0;
			sense_amp_en <= 1'b0;
			interrupt_source_flag <= 1'b0;
			low_voltage_flag <= 1'b0;
			wake_level_one <= 1'b0;
			wake_level_two <= 1'b0;
			in_normal <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			wake_one_prev <= wake_input_one;
			wake_two_prev <= wake_input_two;
			ss_prev <= slave_select;
			lv_prev <= main_supply_low;
			fault_prev <= other_fault;
			regulator_on <= next_regulator_on;
			regulator_limited <= next_regulator_limited;
			reset_out_n <= next_reset_out_n;
			watchdog_active <= next_watchdog_active;
			high_side_switch_one <= next_hs_one;
			high_side_switch_two <= next_hs_two;
			high_side_switch_three <= next_hs_three;
			lin_tx_enable <= next_lin_tx_enable;
			lin_wake_detect_en <= next_lin_wake_detect_en;
			sense_amp_en <= next_sense_amp_en;
			interrupt_source_flag <= next_src_flag;
			low_voltage_flag <= next_lv_flag;
			wake_level_one <= next_wake_one;
			wake_level_two <= next_wake_two;
			in_normal <= (next_state == pwr_pkg::ST_NORMAL);
		end
	end

	sequence s_stop_wake;
		clk_en && (state == pwr_pkg::ST_STOP) && wake_stop;
	endsequence

	sequence s_sleep_wake;
		clk_en && (state == pwr_pkg::ST_SLEEP) && wake_sleep;
	endsequence

	a_cmd_stop: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_NORMAL) && !wd_fail && is_cmd(mode_write, mode_select_field, `MODE_STOP) |=> (state == pwr_pkg::ST_STOP) && regulator_limited && reset_out_n) else $error("stop command not taken");
	a_stop_wake_irq: assert property (@(posedge clk) disable iff (!resetn) s_stop_wake |=> (state == pwr_pkg::ST_NREQ) && !irq_n && interrupt_source_flag) else $error("stop wake not reported");
	a_sleep_wake_rst: assert property (@(posedge clk) disable iff (!resetn) s_sleep_wake |=> (state == pwr_pkg::ST_RESET) && regulator_on && !reset_out_n && !$fell(irq_n)) else $error("sleep wake not via reset");
	a_sleep_ss_ign: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_SLEEP) && ss_rise && !wake_sleep |=> (state == pwr_pkg::ST_SLEEP)) else $error("select edge woke sleep");
	a_low_power_out: assert property (@(posedge clk) disable iff (!resetn) (state == pwr_pkg::ST_STOP) || (state == pwr_pkg::ST_SLEEP) |-> !lin_tx_enable && lin_wake_detect_en && !high_side_switch_one && !high_side_switch_three && !watchdog_active && !sense_amp_en && (reset_out_n == (state == pwr_pkg::ST_STOP))) else $error("low power outputs wrong");
	a_wd_grounded: assert property (@(posedge clk) disable iff (!resetn) $past(clk_en && watchdog_config_pin_grounded) |-> !watchdog_active) else $error("watchdog active with pin grounded");
	a_lv_irq: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_NORMAL) && lv_rise |=> !irq_n && interrupt_source_flag) else $error("low voltage irq missing");
	a_lv_follow: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_NORMAL) && !mode_write && !wd_fail |=> low_voltage_flag == $past(main_supply_low)) else $error("low voltage flag not following");
	a_lv_off_lp: assert property (@(posedge clk) disable iff (!resetn) (state == pwr_pkg::ST_STOP) || (state == pwr_pkg::ST_SLEEP) |-> !low_voltage_flag) else $error("low voltage flag in low power");
	a_src_clear: assert property (@(posedge clk) disable iff (!resetn) clk_en && status_read && !irq_trigger |=> !interrupt_source_flag) else $error("source flag not cleared");
	a_hs_gate: assert property (@(posedge clk) disable iff (!resetn) $rose(high_side_switch_two) |-> $past(direct_pwm_gate_input && switch_two_on_bit)) else $error("switch on without pwm");
	a_hs3_only_bit: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_NORMAL) && !mode_write && !wd_fail && switch_three_on_bit |=> high_side_switch_three) else $error("switch three not on");
	a_wd_fail_rst: assert property (@(posedge clk) disable iff (!resetn) clk_en && wd_fail |=> (state == pwr_pkg::ST_RESET) && !reset_out_n && !lin_tx_enable) else $error("watchdog failure not reset");
	a_wake_read: assert property (@(posedge clk) disable iff (!resetn) clk_en && (state == pwr_pkg::ST_NORMAL) && !mode_write && !wd_fail |=> wake_level_one == $past(wake_input_one)) else $error("wake level not readable");
endmodule
`default_nettype wire

// File: hdl/pwr_defines.svh
/*
 Mode codes, reset values and timing counts for the power-mode controller.
 Assumes a 100 MHz core clock.
*/
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h1
`define MODE_SLEEP 2'h2

`define CLK_HZ 100000000
`define CLK_PERIOD_NS 10

`define NREQ_TIMEOUT_MS 150
`define NREQ_TIMEOUT_CYCLES (`NREQ_TIMEOUT_MS * (`CLK_HZ / 1000))

`define WD_DEFAULT_MS 100
`define WD_DEFAULT_CYCLES (`WD_DEFAULT_MS * (`CLK_HZ / 1000))

`define RESET_HOLD_US 1000
`define RESET_HOLD_CYCLES (`RESET_HOLD_US * (`CLK_HZ / 1000000))

`define IRQ_PULSE_NS 10000
`define IRQ_PULSE_CYCLES ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CNT_W 24
`define PULSE_W 12

`endif

// File: hdl/pwr_pkg.sv
/*
 Types of the power-mode controller.
 Assumes nothing of its surroundings.
*/
package pwr_pkg;
	typedef enum logic [4:0] {
		ST_RESET = 5'b00001,
		ST_NREQ = 5'b00010,
		ST_NORMAL = 5'b00100,
		ST_STOP = 5'b01000,
		ST_SLEEP = 5'b10000
	} mode_state_t;
endpackage

// File: hdl/irq_pulse.sv
/*
 Interrupt pulse stretcher: a trigger gives a low pulse of fixed width.
 Assumes trigger is a one-cycle strobe in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defines.svh"
module irq_pulse (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic trigger,
	output logic irq_n
);
	localparam logic [`PULSE_W-1:0] PULSE = `PULSE_W'(`IRQ_PULSE_CYCLES);
	logic [`PULSE_W-1:0] cnt;
	logic [`PULSE_W-1:0] next_cnt;
	logic next_irq_n;

	// A trigger during a pulse restarts it, so close events merge
	always_comb begin
		next_cnt = cnt;
		if (trigger) begin
			next_cnt = PULSE;
		end else if (cnt != `PULSE_W'h0) begin
			next_cnt = cnt - `PULSE_W'h1;
		end
		next_irq_n = (next_cnt == `PULSE_W'h0);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt <= `PULSE_W'h0;
			irq_n <= 1'b1;
		end else if (clk_en) begin
			cnt <= next_cnt;
			irq_n <= next_irq_n;
		end
	end

	a_pulse_width: assert property (@(posedge clk) disable iff (!resetn) $fell(irq_n) |-> !irq_n [*8]) else $error("irq pulse too short");
endmodule
`default_nettype wire

// File: hdl/window_watchdog.sv
/*
 Watchdog counter: request time-out phase and windowed phase.
 Assumes restart is raised in the cycle of every mode change.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defines.svh"
module window_watchdog (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic restart,
	input wire logic req_phase,
	input wire logic win_phase,
	input wire logic service,
	input wire logic [`CNT_W-1:0] req_cycles,
	input wire logic [`CNT_W-1:0] period_cycles,
	output logic fail
);
	logic [`CNT_W-1:0] cnt;
	logic [`CNT_W-1:0] next_cnt;
	logic next_fail;
	logic window_closed;

	function automatic logic reached(input logic [`CNT_W-1:0] c, input logic [`CNT_W-1:0] lim);
		return c >= lim - `CNT_W'h1;
	endfunction

	// Window closed for the first half of the period
	assign window_closed = cnt < {1'b0, period_cycles[`CNT_W-1:1]};

	always_comb begin
		next_cnt = cnt + `CNT_W'h1;
		next_fail = 1'b0;
		if (restart || !(req_phase || win_phase)) begin
			next_cnt = `CNT_W'h0;
		end else if (req_phase) begin
			if (reached(cnt, req_cycles)) begin
				next_fail = 1'b1;
				next_cnt = `CNT_W'h0;
			end
		end else if (service) begin
			next_cnt = `CNT_W'h0;
			next_fail = window_closed;
		end else if (reached(cnt, period_cycles)) begin
			next_fail = 1'b1;
			next_cnt = `CNT_W'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt <= `CNT_W'h0;
			fail <= 1'b0;
		end else if (clk_en) begin
			cnt <= next_cnt;
			fail <= next_fail;
		end
	end

	a_closed_service: assert property (@(posedge clk) disable iff (!resetn) clk_en && win_phase && !req_phase && !restart && service && window_closed |=> fail) else $error("early service not failed");
	a_req_timeout: assert property (@(posedge clk) disable iff (!resetn) clk_en && req_phase && !restart && reached(cnt, req_cycles) |=> fail && cnt == `CNT_W'h0) else $error("request time-out missed");
endmodule
`default_nettype wire

// File: test/mcu_model.sv
/*
 Microcontroller model: mode writes and status transfers as one-cycle strobes.
 Assumes the design samples its strobes on the rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	input wire logic clk,
	input wire logic reset_out_n,
	output logic mode_write,
	output logic [1:0] mode_select_field,
	output logic status_read
);
	initial begin
		mode_write = 1'b0;
		mode_select_field = 2'h3;
		status_read = 1'b0;
	end
	// No mode write is sent while the reset output holds the controller down
	task automatic write_mode(input logic [1:0] code);
		if (reset_out_n !== 1'b1) return;
		@(posedge clk);
		#1;
		mode_select_field = code;
		mode_write = 1'b1;
		@(posedge clk);
		#1;
		mode_write = 1'b0;
		// Released field carries garbage, not the last code
		mode_select_field = ~code;
	endtask
	task automatic read_status();
		@(posedge clk);
		#1;
		status_read = 1'b1;
		@(posedge clk);
		#1;
		status_read = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
/*
 Self-checking bench: integer mode model against the design's outputs.
 Assumes small timing parameters (40, 64, 8) and a 10 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, resetn, clk_en, mode_write, status_read, main_supply_low;
	logic [1:0] mode_select_field;
	logic watchdog_config_pin_grounded, watchdog_config_pin_open;
	logic [23:0] watchdog_resistor_period;
	logic wake_input_one, wake_input_two, lin_wake, slave_select;
	logic [2:0] other_fault;
	logic direct_pwm_gate_input, switch_one_on_bit, switch_two_on_bit, switch_three_on_bit;
	logic regulator_on, regulator_limited, reset_out_n, watchdog_active;
	logic high_side_switch_one, high_side_switch_two, high_side_switch_three;
	logic lin_tx_enable, lin_wake_detect_en, sense_amp_en, irq_n, interrupt_source_flag;
	logic low_voltage_flag, wake_level_one, wake_level_two, in_normal;
	logic [7:0] r;
	logic [4:0] ex;
	logic trig;
	int fails, tests_run, mdl, n;
	power_mode_and_fault_irq_control #(
		.NREQ_TIMEOUT(24'h28),
		.WD_DEFAULT(24'h40),
		.RESET_HOLD(24'h8)
	) power_mode_and_fault_irq_control_inst (
		.clk, .resetn, .clk_en, .mode_write, .mode_select_field, .status_read,
		.watchdog_config_pin_grounded, .watchdog_config_pin_open, .watchdog_resistor_period,
		.wake_input_one, .wake_input_two, .lin_wake, .slave_select, .main_supply_low,
		.other_fault, .direct_pwm_gate_input, .switch_one_on_bit, .switch_two_on_bit,
		.switch_three_on_bit, .regulator_on, .regulator_limited, .reset_out_n,
		.watchdog_active, .high_side_switch_one, .high_side_switch_two,
		.high_side_switch_three, .lin_tx_enable, .lin_wake_detect_en, .sense_amp_en,
		.irq_n, .interrupt_source_flag, .low_voltage_flag, .wake_level_one,
		.wake_level_two, .in_normal
	);
	mcu_model mcu_model_inst (.clk, .reset_out_n, .mode_write, .mode_select_field, .status_read);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Model modes: 0 reset, 1 normal request, 2 normal, 3 stop, 4 sleep
	task automatic check_mode();
		chk(regulator_on, mdl != 4, "regulator on");
		chk(regulator_limited, mdl == 3, "regulator limit");
		chk(reset_out_n, mdl inside {1, 2, 3}, "reset output");
		chk(lin_tx_enable, mdl inside {1, 2}, "lin transmit");
		chk(lin_wake_detect_en, mdl inside {3, 4}, "lin wake");
		chk(sense_amp_en, mdl == 2, "sense amp");
		chk(in_normal, mdl == 2, "normal");
		chk(watchdog_active, mdl inside {1, 2} && !watchdog_config_pin_grounded, "wd on");
	endtask
	task automatic wait_rst(input logic lvl, input int lim);
		n = 0;
		while (reset_out_n !== lvl && n < lim) begin
			cyc(1);
			n++;
		end
		chk(reset_out_n, lvl, "reset output wait");
	endtask
	initial begin
		#100000;
		fails++;
		complete_run();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		{main_supply_low, watchdog_config_pin_open, wake_input_one, wake_input_two} = 4'h0;
		{lin_wake, slave_select, other_fault, direct_pwm_gate_input} = 6'h00;
		{switch_one_on_bit, switch_two_on_bit, switch_three_on_bit} = 3'h0;
		watchdog_config_pin_grounded = 1'b1;
		watchdog_resistor_period = 24'h40;
		fails = 0;
		tests_run = 0;
		mdl = 0;
		void'($urandom(39460));
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		check_mode();
		wait_rst(1'b1, 50);
		mdl = 1;
		check_mode();
		$display("test reset done");
		mcu_model_inst.write_mode(2'h0);
		cyc(1);
		mdl = 2;
		check_mode();
		ex = 5'h00;
		for (int i = 0; i < 12; i++) begin
			r = 8'($urandom);
			// A low enable freezes every output
			clk_en = r[6] | r[7];
			{switch_one_on_bit, switch_two_on_bit, switch_three_on_bit} = r[2:0];
			{direct_pwm_gate_input, wake_input_one, wake_input_two} = r[5:3];
			cyc(2);
			if (clk_en) ex = {r[2] & r[5], r[1] & r[5], r[0], r[4], r[3]};
			chk(high_side_switch_one, ex[4], "switch one");
			chk(high_side_switch_two, ex[3], "switch two");
			chk(high_side_switch_three, ex[2], "switch three");
			chk(wake_level_one, ex[1], "wake level one");
			chk(wake_level_two, ex[0], "wake level two");
		end
		clk_en = 1'b1;
		mcu_model_inst.write_mode(2'h3);
		cyc(1);
		check_mode();
		$display("test switches done");
		for (int i = 0; i < 4; i++) begin
			mcu_model_inst.read_status();
			cyc(1);
			chk(interrupt_source_flag, 1'b0, "flag cleared");
			if (i == 0) main_supply_low = 1'b1;
			else other_fault[i-1] = 1'b1;
			cyc(2);
			chk(irq_n, 1'b0, "irq pulse");
			chk(interrupt_source_flag, 1'b1, "flag set");
		end
		chk(low_voltage_flag, 1'b1, "lv flag held");
		for (int i = 0; i < 16; i++) begin
			r = 8'($urandom);
			trig = (r[3] & !main_supply_low) | (|(r[2:0] & ~other_fault));
			{main_supply_low, other_fault} = r[3:0];
			lin_wake = r[4] & !lin_wake;
			slave_select = r[5];
			cyc(1);
			chk(low_voltage_flag, r[3], "lv flag random");
			chk(in_normal, 1'b1, "no wake in normal");
			if (trig) begin
				chk(irq_n, 1'b0, "irq random");
				chk(interrupt_source_flag, 1'b1, "flag random");
			end
		end
		lin_wake = 1'b0;
		slave_select = 1'b0;
		main_supply_low = 1'b0;
		other_fault = 3'h0;
		cyc(2);
		chk(low_voltage_flag, 1'b0, "lv flag gone");
		$display("test interrupts done");
		for (int i = 0; i < 3; i++) begin
			mcu_model_inst.write_mode(2'h1);
			cyc(1);
			mdl = 3;
			check_mode();
			chk(high_side_switch_three, 1'b0, "switch in stop");
			mcu_model_inst.read_status();
			if (i == 0) begin
				main_supply_low = 1'b1;
				cyc(3);
				chk(interrupt_source_flag, 1'b0, "lv off in stop");
				main_supply_low = 1'b0;
			end
			if (i == 0) wake_input_one = ~wake_input_one;
			if (i == 1) lin_wake = 1'b1;
			if (i == 2) slave_select = 1'b1;
			cyc(1);
			lin_wake = 1'b0;
			cyc(1);
			mdl = 1;
			check_mode();
			chk(irq_n, 1'b0, "wake irq");
			chk(interrupt_source_flag, 1'b1, "wake flag");
			slave_select = 1'b0;
			mcu_model_inst.write_mode(2'h0);
			cyc(1);
			mdl = 2;
		end
		$display("test stop done");
		n = 0;
		while (irq_n !== 1'b1 && n < 1100) begin
			cyc(1);
			n++;
		end
		mcu_model_inst.write_mode(2'h2);
		cyc(1);
		mdl = 4;
		check_mode();
		slave_select = 1'b1;
		cyc(3);
		check_mode();
		watchdog_config_pin_grounded = 1'b0;
		watchdog_config_pin_open = 1'b1;
		wake_input_two = ~wake_input_two;
		cyc(2);
		mdl = 0;
		check_mode();
		chk(irq_n, 1'b1, "no irq from sleep");
		slave_select = 1'b0;
		wait_rst(1'b1, 50);
		mdl = 1;
		$display("test sleep done");
		cyc(30);
		chk(reset_out_n, 1'b1, "request still waiting");
		wait_rst(1'b0, 20);
		wait_rst(1'b1, 50);
		mcu_model_inst.write_mode(2'h0);
		mcu_model_inst.write_mode(2'h0);
		wait_rst(1'b0, 10);
		wait_rst(1'b1, 50);
		mcu_model_inst.write_mode(2'h0);
		cyc(40);
		mcu_model_inst.write_mode(2'h0);
		cyc(20);
		chk(reset_out_n, 1'b1, "service in open window");
		wait_rst(1'b0, 80);
		watchdog_config_pin_open = 1'b0;
		watchdog_resistor_period = 24'(48 + $urandom % 32);
		wait_rst(1'b1, 50);
		mcu_model_inst.write_mode(2'h0);
		n = 0;
		while (reset_out_n === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		// Unserved: fail at count period-1, reset low two cycles later
		chk(n == watchdog_resistor_period + 1, 1'b1, "resistor period");
		watchdog_config_pin_grounded = 1'b1;
		wait_rst(1'b1, 50);
		mdl = 1;
		cyc(60);
		check_mode();
		$display("test watchdog done");
		complete_run();
	end
endmodule
`default_nettype wire
